// File: common/ram_block_pkg.sv
// Shared constants, types and register map of the embedded RAM block
package ram_block_pkg;
    localparam int BLOCK_BITS = 2048;
    localparam int MAX_WIDTH = 8;
    localparam int ADDR_W = 11;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BASE_DEPTH = 12'h0100;
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] OFS_CONFIG = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_LOAD_ADDR = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_LOAD_DATA = 12'h00C;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_RAM,
        MODE_ROM,
        MODE_DUAL,
        MODE_FIFO
    } mode_e;

    // Shape: 0 = 256x8, 1 = 512x4, 2 = 1024x2, 3 = 2048x1
    typedef struct packed {
        logic reg_out;
        logic reg_addr;
        logic reg_din;
        mode_e mode;
        logic [1:0] shape;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, MODE_RAM, 2'h0};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic in_clk;
        logic out_clk;
        logic block_sel;
        logic [ADDR_W-1:0] addr;
        logic [MAX_WIDTH-1:0] wdata;
        logic we;
        logic [ADDR_W-1:0] rd_addr;
        logic rd_en;
    } user_in_s;
endpackage : ram_block_pkg

// File: rtl/embedded_ram_block.sv
// Configurable 2048-bit embedded RAM/ROM block with APB control
// Notes on behaviour
// R1: Storage is 2048 bits, shaped as 256x8, 512x4, 1024x2 or 2048x1.
// R2: Address width in use is 8, 9, 10 or 11 bits following the shape.
// R3: The block makes its own write strobe from the input clock edge.
// R4: In ROM use contents are loaded at configuration and reads return them.
// R5: Input registers use one clock and the output register another.
// R6: Data-in, data-out and address/write-enable registers are each optional.
// R7: Blocks sharing address and control combine side by side for width.
// R8: Blocks cascade in depth through block select without extra latency.
// R9: Write enable may come from a global signal or from user logic.
// R10: Block clocks may come from a global line, a pin or user logic.
// R11: Dual-port RAM and FIFO use are built on the same storage bits.
// R12: Bypassed paths follow combinationally; registered ones change on edges.
// R13: Reset clears the path registers but leaves stored contents alone.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module embedded_ram_block (
    input wire logic pclk,
    input wire logic presetn,
    input wire ram_block_pkg::apb_req_s apb_req,
    output ram_block_pkg::apb_rsp_s apb_rsp,
    input wire ram_block_pkg::user_in_s user_in,
    output logic [ram_block_pkg::MAX_WIDTH-1:0] rdata
);
    import ram_block_pkg::*;

    typedef struct packed {
        cfg_s cfg;
        logic [ADDR_W-1:0] load_addr;
        logic in_prev;
        logic out_prev;
        logic [ADDR_W-1:0] addr_q;
        logic [ADDR_W-1:0] rd_addr_q;
        logic we_q;
        logic [MAX_WIDTH-1:0] din_q;
        logic [MAX_WIDTH-1:0] dout_q;
        logic [ADDR_W-1:0] wptr;
        logic [ADDR_W-1:0] rptr;
        logic [CNT_W-1:0] count;
        apb_rsp_s rsp;
    } state_s;

    state_s st;
    state_s next_st;
    logic mem [BLOCK_BITS];
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [MAX_WIDTH-1:0] mem_wdata;
    logic [MAX_WIDTH-1:0] raw_rd;
    logic [CNT_W-1:0] mem_base;

    // =========================================================
    // Shape helpers
    function automatic logic [CNT_W-1:0] depth_of(input logic [1:0] shape);
        depth_of = BASE_DEPTH << shape; // [R1] [R2]
    endfunction : depth_of

    function automatic logic [ADDR_W-1:0] mask_addr(
        input logic [ADDR_W-1:0] a, input logic [1:0] shape);
        logic [CNT_W-1:0] lim;
        lim = depth_of(shape) - 12'h001;
        mask_addr = a & lim[ADDR_W-1:0]; // [R2]
    endfunction : mask_addr

    function automatic logic [CNT_W-1:0] bit_base(
        input logic [ADDR_W-1:0] a, input logic [1:0] shape);
        bit_base = {1'b0, a} << (2'h3 - shape);
    endfunction : bit_base

    function automatic logic [3:0] width_of(input logic [1:0] shape);
        width_of = 4'h8 >> shape; // [R1]
    endfunction : width_of

    function automatic logic [MAX_WIDTH-1:0] read_word(
        input logic [ADDR_W-1:0] a, input logic [1:0] shape);
        logic [CNT_W-1:0] base;
        base = bit_base(a, shape);
        read_word = '0;
        for (int b = 0; b < MAX_WIDTH; b++) begin
            if (4'(b) < width_of(shape)) begin
                read_word[b] = mem[base[ADDR_W-1:0] + ADDR_W'(b)];
            end
        end
    endfunction : read_word

    // =========================================================
    // Next-state logic
    always_comb begin
        logic in_edge;
        logic out_edge;
        logic access;
        logic [ADDR_W-1:0] addr_eff;
        logic [ADDR_W-1:0] rd_eff;
        logic we_eff;
        logic [MAX_WIDTH-1:0] din_eff;
        logic [ADDR_W-1:0] rd_sel;
        logic push;
        logic pop;
        logic [CNT_W-1:0] depth;
        in_edge = 1'b0;
        out_edge = 1'b0;
        access = 1'b0;
        addr_eff = '0;
        rd_eff = '0;
        we_eff = 1'b0;
        din_eff = '0;
        rd_sel = '0;
        push = 1'b0;
        pop = 1'b0;
        depth = '0;
        next_st = st;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;

        // Clock pins are sampled; their rising edges time each side
        next_st.in_prev = user_in.in_clk; // [R5] [R10]
        next_st.out_prev = user_in.out_clk; // [R5] [R10]
        in_edge = user_in.in_clk & ~st.in_prev;
        out_edge = user_in.out_clk & ~st.out_prev;
        depth = depth_of(st.cfg.shape);

        // Optional input registers, captured on the input clock edge
        if (in_edge) begin
            next_st.addr_q = user_in.addr; // [R6]
            next_st.rd_addr_q = user_in.rd_addr; // [R6]
            next_st.we_q = user_in.we; // [R6] [R9]
            next_st.din_q = user_in.wdata; // [R6]
        end
        addr_eff = st.cfg.reg_addr ? st.addr_q : user_in.addr; // [R6]
        rd_eff = st.cfg.reg_addr ? st.rd_addr_q : user_in.rd_addr;
        we_eff = st.cfg.reg_addr ? st.we_q : user_in.we; // [R6] [R9]
        din_eff = st.cfg.reg_din ? st.din_q : user_in.wdata; // [R6]
        addr_eff = mask_addr(addr_eff, st.cfg.shape);
        rd_eff = mask_addr(rd_eff, st.cfg.shape);

        // Read port address per mode
        if (st.cfg.mode == MODE_FIFO) begin
            rd_sel = st.rptr; // [R11]
        end else if (st.cfg.mode == MODE_DUAL) begin
            rd_sel = rd_eff; // [R11]
        end else begin
            rd_sel = addr_eff; // [R4]
        end
        raw_rd = read_word(rd_sel, st.cfg.shape);
        // A deselected block clears its output so cascaded outputs can be ORed
        if (!user_in.block_sel) begin
            next_st.dout_q = '0; // [R8]
        end else if (out_edge) begin
            next_st.dout_q = raw_rd; // [R12]
        end

        // FIFO pointers
        push = in_edge & we_eff & user_in.block_sel
            & (st.count != depth) & (st.cfg.mode == MODE_FIFO);
        pop = in_edge & user_in.rd_en & user_in.block_sel
            & (st.count != '0) & (st.cfg.mode == MODE_FIFO);
        if (push) begin
            next_st.wptr = mask_addr(st.wptr + 11'h001, st.cfg.shape);
        end
        if (pop) begin
            next_st.rptr = mask_addr(st.rptr + 11'h001, st.cfg.shape);
        end
        if (push & ~pop) begin
            next_st.count = st.count + 12'h001; // [R11]
        end else if (pop & ~push) begin
            next_st.count = st.count - 12'h001; // [R11]
        end

        // Self-timed write strobe on the input clock edge
        if (push) begin
            mem_we = 1'b1;
            mem_waddr = st.wptr;
            mem_wdata = din_eff;
        end else if (in_edge & we_eff & user_in.block_sel
            & (st.cfg.mode != MODE_ROM) & (st.cfg.mode != MODE_FIFO)) begin
            mem_we = 1'b1; // [R3] [R7] [R8]
            mem_waddr = addr_eff;
            mem_wdata = din_eff;
        end

        // APB slave: access phase is answered one cycle after it starts
        next_st.rsp.pready = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        next_st.rsp.prdata = READ_ZERO;
        access = apb_req.psel & apb_req.penable & ~st.rsp.pready;
        if (access) begin
            next_st.rsp.pready = 1'b1;
            if (apb_req.paddr == OFS_CONFIG) begin
                next_st.rsp.prdata = {25'h000_0000, st.cfg};
                if (apb_req.pwrite) begin
                    next_st.cfg = cfg_s'(apb_req.pwdata[$bits(cfg_s)-1:0]);
                    next_st.wptr = '0;
                    next_st.rptr = '0;
                    next_st.count = '0;
                end
            end else if (apb_req.paddr == OFS_STATUS) begin
                next_st.rsp.prdata = {16'h0000, st.count,
                    2'h0, st.count == '0, st.count == depth};
            end else if (apb_req.paddr == OFS_LOAD_ADDR) begin
                next_st.rsp.prdata = {21'h00_0000, st.load_addr};
                if (apb_req.pwrite) begin
                    next_st.load_addr = apb_req.pwdata[ADDR_W-1:0];
                end
            end else if (apb_req.paddr == OFS_LOAD_DATA) begin
                next_st.rsp.prdata = {24'h00_0000,
                    read_word(mask_addr(st.load_addr, st.cfg.shape),
                    st.cfg.shape)};
                if (apb_req.pwrite) begin
                    // Contents loaded by software, the configuration path
                    mem_we = 1'b1; // [R4]
                    mem_waddr = mask_addr(st.load_addr, st.cfg.shape);
                    mem_wdata = apb_req.pwdata[MAX_WIDTH-1:0];
                    next_st.load_addr = st.load_addr + 11'h001;
                end
            end else begin
                next_st.rsp.pslverr = 1'b1;
            end
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{cfg: CFG_RESET, default: '0}; // [R13]
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // Storage, never reset
    assign mem_base = bit_base(mem_waddr, st.cfg.shape);

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            for (int b = 0; b < MAX_WIDTH; b++) begin
                if (4'(b) < width_of(st.cfg.shape)) begin
                    mem[mem_base[ADDR_W-1:0] + ADDR_W'(b)] <= mem_wdata[b]; // [R13]
                end
            end
        end
    end

    assign apb_rsp = st.rsp;
    // Bypassed output path follows the read address directly
    assign rdata = st.cfg.reg_out ? st.dout_q
        : (user_in.block_sel ? raw_rd : '0); // [R6] [R12] [R8]
endmodule : embedded_ram_block
`default_nettype wire

// File: verification/ram_block_checker.sv
// Checker for the APB and user side of the embedded RAM block
`timescale 1ns/100ps
`default_nettype none
module ram_block_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire ram_block_pkg::apb_req_s apb_req,
    input wire ram_block_pkg::apb_rsp_s apb_rsp,
    input wire ram_block_pkg::user_in_s user_in,
    input wire logic [ram_block_pkg::MAX_WIDTH-1:0] rdata
);
    import ram_block_pkg::*;
    logic acc;
    logic hit;
    assign acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    assign hit = apb_req.paddr inside {OFS_CONFIG, OFS_STATUS,
        OFS_LOAD_ADDR, OFS_LOAD_DATA};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // Assertions
    a_ready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready) else $error("pready long");
    a_ready_answer: assert property (
        acc |=> apb_rsp.pready) else $error("pready late");
    a_ready_cause: assert property (
        apb_rsp.pready |-> $past(acc)) else $error("pready unasked");
    a_error_map: assert property (
        acc |=> apb_rsp.pslverr == !$past(hit)) else $error("pslverr bad");
    a_error_ready: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr alone");
    a_error_data: assert property (
        apb_rsp.pslverr |-> apb_rsp.prdata == '0) else $error("err data");
    a_reset_quiet: assert property (
        $rose(presetn) |-> !apb_rsp.pready) else $error("ready at reset");
    a_sel_low: assert property (
        !user_in.block_sel [*2] |-> rdata == '0) else $error("sel low data");
endmodule : ram_block_checker
bind embedded_ram_block ram_block_checker u_chk (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .user_in(user_in), .rdata(rdata));
`default_nettype wire

// File: verification/test_configurable_embedded_ram_block.sv
// Self-checking bench for the configurable embedded RAM block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_configurable_embedded_ram_block;
    import ram_block_pkg::*;
    logic pclk;
    logic presetn;
    apb_req_s req;
    apb_rsp_s rsp;
    user_in_s user_in;
    logic [MAX_WIDTH-1:0] rdata;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 93471;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [7:0] d;
    logic [7:0] m;
    logic [10:0] a;
    embedded_ram_block dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .user_in(user_in), .rdata(rdata));
    user_logic_model u_user (.pclk(pclk), .user_in(user_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // ====
    // APB master; the expected answer is queued for the watcher
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
        input logic [33:0] x);
        int n;
        q.push_back(x);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, ad, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            stop_test;
        end
        req <= '0;
    endtask : apb
    task wr(input logic [11:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd, 34'h0_0000_0000);
    endtask : wr
    task rd(input logic [11:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0000_0000, {2'b10, x});
    endtask : rd
    always @(posedge pclk) begin
        if (presetn === 1'b1 && rsp.pready === 1'b1) begin
            e = q.pop_front();
            `CHECK("pslverr", e[32], rsp.pslverr)
            if (e[33]) `CHECK("prdata", e[31:0], rsp.prdata)
        end
    end
    task chk(input string n, input logic [7:0] x);
        repeat (2) @(posedge pclk);
        `CHECK(n, x, rdata)
    endtask : chk
    // ====
    // Scenarios
    initial begin
        presetn = 1'b0;
        req = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CONFIG, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0002);
        u_user.sel(1'b1);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CONFIG, 32'(s));
            m = 8'((16'h0001 << (8 >> s)) - 1);
            a = 11'((BASE_DEPTH << s) - 1);
            d = 8'($random(seed));
            u_user.step(a, d, 1'b1, 1'b0);
            chk("shape word", d & m);
            u_user.step(a | 11'h400, 8'h00, 1'b0, 1'b0);
            chk("addr mask", d & m);
            $display("shape %0d done", s);
        end
        wr(OFS_CONFIG, 32'h0000_0004);
        wr(OFS_LOAD_ADDR, 32'h0000_0005);
        d = 8'($random(seed));
        wr(OFS_LOAD_DATA, {24'h00_0000, d});
        rd(OFS_LOAD_ADDR, 32'h0000_0006);
        u_user.step(11'h005, ~d, 1'b1, 1'b0);
        chk("rom word", d);
        apb(1'b1, 12'h010, 32'h0000_0000, 34'h1_0000_0000);
        $display("rom done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        u_user.step(11'h005, 8'h00, 1'b0, 1'b0);
        chk("kept word", d);
        wr(OFS_CONFIG, 32'h0000_0040);
        u_user.step(11'h005, 8'h00, 1'b0, 1'b1);
        chk("reg out", d);
        u_user.step(11'h006, 8'h3C, 1'b1, 1'b0);
        chk("held out", d);
        u_user.step(11'h006, 8'h00, 1'b0, 1'b1);
        chk("new out", 8'h3C);
        $display("registers done");
        wr(OFS_CONFIG, 32'h0000_0000);
        u_user.sel(1'b0);
        u_user.step(11'h006, 8'hA5, 1'b1, 1'b0);
        chk("deselected", 8'h00);
        u_user.sel(1'b1);
        u_user.step(11'h006, 8'h00, 1'b0, 1'b0);
        chk("not written", 8'h3C);
        $display("select done");
        wr(OFS_CONFIG, 32'h0000_0010);
        u_user.step(11'h020, 8'h5A, 1'b1, 1'b0);
        u_user.step(11'h021, 8'h96, 1'b1, 1'b0);
        chk("reg din", 8'h5A);
        wr(OFS_CONFIG, 32'h0000_0020);
        u_user.step(11'h022, 8'h77, 1'b1, 1'b0);
        u_user.step(11'h023, 8'h88, 1'b1, 1'b0);
        wr(OFS_CONFIG, 32'h0000_0000);
        u_user.step(11'h022, 8'h00, 1'b0, 1'b0);
        chk("reg addr", 8'h88);
        $display("inputs done");
        wr(OFS_CONFIG, 32'h0000_0008);
        u_user.step(11'h030, 8'h4B, 1'b1, 1'b0);
        u_user.step(11'h031, 8'h00, 1'b0, 1'b0);
        u_user.read_port(11'h030, 1'b0);
        chk("dual read", 8'h4B);
        $display("dual done");
        wr(OFS_CONFIG, 32'h0000_000C);
        u_user.step(11'h000, 8'h12, 1'b1, 1'b0);
        u_user.step(11'h000, 8'h34, 1'b1, 1'b0);
        chk("fifo head", 8'h12);
        rd(OFS_STATUS, 32'h0000_0020);
        u_user.read_port(11'h000, 1'b1);
        chk("fifo next", 8'h34);
        u_user.read_port(11'h000, 1'b1);
        u_user.read_port(11'h000, 1'b1);
        rd(OFS_STATUS, 32'h0000_0002);
        $display("fifo done");
        stop_test;
    end
endmodule : test_configurable_embedded_ram_block
`default_nettype wire

// File: verification/user_logic_model.sv
// Model of the user logic that drives the block's user side
`timescale 1ns/100ps
`default_nettype none
module user_logic_model (
    input wire logic pclk,
    output var ram_block_pkg::user_in_s user_in
);
    import ram_block_pkg::*;
    initial user_in = '0;
    task automatic sel(input logic s);
        @(posedge pclk);
        user_in.block_sel <= s;
    endtask : sel
    // in_clk pulses only with a write and out_clk only on request, one cycle each, then both stand still low
    task automatic step(input logic [10:0] a, input logic [7:0] d,
        input logic w, input logic o);
        @(posedge pclk);
        user_in.addr <= a;
        user_in.wdata <= d;
        user_in.we <= w;
        user_in.in_clk <= w;
        user_in.out_clk <= o;
        @(posedge pclk);
        user_in.in_clk <= 1'b0;
        user_in.out_clk <= 1'b0;
        user_in.we <= 1'b0;
        user_in.wdata <= ~d;
    endtask : step
    // Read port address, and a pop that pulses the input clock
    task automatic read_port(input logic [10:0] ra, input logic r);
        @(posedge pclk);
        user_in.rd_addr <= ra;
        user_in.rd_en <= r;
        user_in.in_clk <= r;
        @(posedge pclk);
        user_in.in_clk <= 1'b0;
        user_in.rd_en <= 1'b0;
    endtask : read_port
endmodule : user_logic_model
`default_nettype wire
